// file: vcc_pkg.sv
// constants for the video channel control register bank
package vcc_pkg;
    localparam int VCC_ADDR_W = 12;
    localparam logic [11:0] VCC_CHANNEL2_CONTROL_OFS = 12'h000;
    localparam logic [11:0] VCC_CHANNEL3_CONTROL_OFS = 12'h004;
    localparam int VCC_BIT_ACTIVE = 0;
    localparam int VCC_BIT_CLKGATE = 1;
    localparam int VCC_BIT_BLANK_CLIP = 14;
    localparam int VCC_BIT_EDGE_SEL = 31;
    localparam logic [31:0] VCC_CH2_RW_MASK = 32'h0000_0003;
    localparam logic [31:0] VCC_CH3_RW_MASK = 32'h8000_4003;
    localparam logic [31:0] VCC_CTRL_RESET = 32'h0000_0000;
    localparam int VCC_CH2_SHADOW_W = 1;
    localparam int VCC_CH3_SHADOW_W = 3;
    typedef enum logic [1:0] {
        VCC_REG_CH2 = 2'h0,
        VCC_REG_CH3 = 2'h1,
        VCC_REG_NONE = 2'h3
    } vcc_reg_t;
endpackage

// file: vcc_shadow.sv
// frame-boundary shadow copy of channel settings
`timescale 1ns/10ps
module vcc_shadow #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // load strobe and value
    input wire logic load,
    input wire logic [W-1:0] dIn,
    output logic [W-1:0] qOut
);
    logic [W-1:0] shadow_d;

    // a zero-width shadow would leave the outputs undriven
    if (W < 1) begin : g_widthCheck
        $error("vcc_shadow: width must be at least 1");
    end

    always_comb begin
        shadow_d = load ? dIn : qOut;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qOut <= '0;
        end else begin
            qOut <= shadow_d;
        end
    end
endmodule

// file: vcc_regs.sv
// apb register bank for video channel 2 and 3 control
//
// What this block does
// - channel 2 clock gate bit: 0 stops the channel 2 clock, 1 runs it.
// - channel 2 clock gate takes effect at the write, not at vsync.
// - channel 2 data and clock output enables follow clock gate directly.
// - channel 2 is active when its enable bit is 1, disabled at 0.
// - channel 3 bit 31 picks input data edge: 0 rising, 1 falling.
// - edge select is only exported; edge handling lives outside this block.
// - channel 3 bit 14 at 0 disables blanking-region clipping.
// - channel 3 bit 14 at 1 enables blanking-region clipping.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module vcc_regs
    import vcc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [VCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame boundaries from the channel datapaths
    input wire logic ch2Vsync,
    input wire logic ch3Vsync,
    // channel 2 controls
    output logic chan2ClockGate,
    output logic chan2Active,
    output logic chan2DataOutputEnableN,
    output logic chan2ClockOutputEnableN,
    // channel 3 controls
    output logic chan3ClockGate,
    output logic chan3Active,
    output logic chan3DataOutputEnableN,
    output logic chan3ClockOutputEnableN,
    output logic chan3InputEdgeSelect,
    output logic chan3BlankingClip
);
    function automatic vcc_reg_t regIndex(input logic [VCC_ADDR_W-1:0] a);
        if (a == VCC_CHANNEL2_CONTROL_OFS) begin
            return VCC_REG_CH2;
        end else if (a == VCC_CHANNEL3_CONTROL_OFS) begin
            return VCC_REG_CH3;
        end else begin
            return VCC_REG_NONE;
        end
    endfunction

    logic [31:0] ch2Ctrl_q, ch2Ctrl_d, ch3Ctrl_q, ch3Ctrl_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic ch2Gate_d, ch3Gate_d;
    logic setup, wrAccess, load2, load3;
    vcc_reg_t sel;
    logic [VCC_CH2_SHADOW_W-1:0] sh2;
    logic [VCC_CH3_SHADOW_W-1:0] sh3;

    assign setup = psel && !penable;
    assign wrAccess = psel && penable && pready && pwrite;
    assign sel = regIndex(paddr);

    // bus and register state
    always_comb begin
        ch2Ctrl_d = ch2Ctrl_q;
        ch3Ctrl_d = ch3Ctrl_q;
        prdata_d = prdata;
        pslverr_d = 1'b0;
        pready_d = setup;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (sel == VCC_REG_CH2) begin
                prdata_d = ch2Ctrl_q;
            end else if (sel == VCC_REG_CH3) begin
                prdata_d = ch3Ctrl_q;
            end else begin
                pslverr_d = 1'b1;
            end
        end
        // reserved bits never store, so they read back as zero
        if (wrAccess && !pslverr) begin
            if (sel == VCC_REG_CH2) begin
                ch2Ctrl_d = pwdata & VCC_CH2_RW_MASK;
            end else if (sel == VCC_REG_CH3) begin
                ch3Ctrl_d = pwdata & VCC_CH3_RW_MASK;
            end
        end
        // clock gates bypass the shadow so they act at the write itself
        ch2Gate_d = ch2Ctrl_d[VCC_BIT_CLKGATE];
        ch3Gate_d = ch3Ctrl_d[VCC_BIT_CLKGATE];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch2Ctrl_q <= VCC_CTRL_RESET;
            ch3Ctrl_q <= VCC_CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            chan2ClockGate <= 1'b0;
            chan3ClockGate <= 1'b0;
            chan2DataOutputEnableN <= 1'b1;
            chan2ClockOutputEnableN <= 1'b1;
            chan3DataOutputEnableN <= 1'b1;
            chan3ClockOutputEnableN <= 1'b1;
        end else begin
            ch2Ctrl_q <= ch2Ctrl_d;
            ch3Ctrl_q <= ch3Ctrl_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            chan2ClockGate <= ch2Gate_d;
            chan3ClockGate <= ch3Gate_d;
            chan2DataOutputEnableN <= !ch2Gate_d;
            chan2ClockOutputEnableN <= !ch2Gate_d;
            chan3DataOutputEnableN <= !ch3Gate_d;
            chan3ClockOutputEnableN <= !ch3Gate_d;
        end
    end

    // an idle channel has no vsync, so its shadow follows the register freely
    assign load2 = ch2Vsync || !sh2[0];
    assign load3 = ch3Vsync || !sh3[0];

    vcc_shadow #(.W(VCC_CH2_SHADOW_W)) u_shadow2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(load2),
        .dIn(ch2Ctrl_q[VCC_BIT_ACTIVE]),
        .qOut(sh2)
    );

    vcc_shadow #(.W(VCC_CH3_SHADOW_W)) u_shadow3 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(load3),
        .dIn({ch3Ctrl_q[VCC_BIT_EDGE_SEL], ch3Ctrl_q[VCC_BIT_BLANK_CLIP],
              ch3Ctrl_q[VCC_BIT_ACTIVE]}),
        .qOut(sh3)
    );

    assign chan2Active = sh2[0];
    assign chan3Active = sh3[0];
    assign chan3InputEdgeSelect = sh3[2];
    assign chan3BlankingClip = sh3[1];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_clkgate2;
        wrAccess && !pslverr && sel == VCC_REG_CH2
            |=> chan2ClockGate == $past(pwdata[VCC_BIT_CLKGATE]);
    endproperty
    a_clkgate2: assert property (p_clkgate2) else $error("ch2 clock gate not updated");

    property p_oe2;
        chan2DataOutputEnableN == !chan2ClockGate && chan2ClockOutputEnableN == !chan2ClockGate;
    endproperty
    a_oe2: assert property (p_oe2) else $error("ch2 output enables differ from gate");

    property p_active2;
        $changed(chan2Active) |-> $past(load2) && chan2Active == $past(ch2Ctrl_q[0]);
    endproperty
    a_active2: assert property (p_active2) else $error("ch2 active changed wrongly");

    property p_edge3;
        $changed(chan3InputEdgeSelect)
            |-> $past(load3) && chan3InputEdgeSelect == $past(ch3Ctrl_q[VCC_BIT_EDGE_SEL]);
    endproperty
    a_edge3: assert property (p_edge3) else $error("ch3 edge select mismatch");

    property p_edgeHold;
        !load3 |=> $stable(chan3InputEdgeSelect);
    endproperty
    a_edgeHold: assert property (p_edgeHold) else $error("ch3 edge select moved");

    property p_clipOff;
        load3 && !ch3Ctrl_q[14] |=> !chan3BlankingClip;
    endproperty
    a_clipOff: assert property (p_clipOff) else $error("ch3 clip not disabled");

    property p_clipOn;
        load3 && ch3Ctrl_q[14] |=> chan3BlankingClip;
    endproperty
    a_clipOn: assert property (p_clipOn) else $error("ch3 clip not enabled");

    property p_ch3gate;
        wrAccess && !pslverr && sel == VCC_REG_CH3
            |=> chan3ClockGate == $past(pwdata[1]) && chan3DataOutputEnableN == !$past(pwdata[1]);
    endproperty
    a_ch3gate: assert property (p_ch3gate) else $error("ch3 gate or enable wrong");

    property p_ready;
        setup |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready timing wrong");

    property p_active3;
        $changed(chan3Active)
            |-> $past(load3) && chan3Active == $past(ch3Ctrl_q[VCC_BIT_ACTIVE]);
    endproperty
    a_active3: assert property (p_active3) else $error("ch3 active changed wrongly");

    // a write to a hole must leave both control words untouched
    property p_holeWrite;
        wrAccess && sel == VCC_REG_NONE |=> $stable(ch2Ctrl_q) && $stable(ch3Ctrl_q);
    endproperty
    a_holeWrite: assert property (p_holeWrite) else $error("hole write stored");

    // the gate only moves at a channel 2 write, never at a vsync
    property p_gateHold2;
        !(wrAccess && !pslverr && sel == VCC_REG_CH2) |=> $stable(chan2ClockGate);
    endproperty
    a_gateHold2: assert property (p_gateHold2) else $error("ch2 gate moved alone");

    c_gateOn: cover property (wrAccess && sel == VCC_REG_CH2 ##1 chan2ClockGate);
    c_active3: cover property ($rose(chan3Active) ##[1:20] ch3Vsync);
    c_badAddr: cover property (pready && pslverr);
endmodule

// file: vcc_regs_bench.sv
// self-checking bench for the video channel control register bank
`timescale 1ns/10ps
module vcc_regs_bench;
    import vcc_pkg::*;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic psel = 0, penable = 0, pwrite = 0, ch2Vsync = 0, ch3Vsync = 0;
    logic [VCC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rdData, val;
    logic pready, pslverr, errSeen;
    logic g2, a2, d2n, c2n, g3, a3, d3n, c3n, e3, b3;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 35;
    always #2.5 clk_sys = ~clk_sys;
    vcc_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch2Vsync(ch2Vsync), .ch3Vsync(ch3Vsync), .chan2ClockGate(g2),
        .chan2Active(a2), .chan2DataOutputEnableN(d2n), .chan2ClockOutputEnableN(c2n),
        .chan3ClockGate(g3), .chan3Active(a3), .chan3DataOutputEnableN(d3n),
        .chan3ClockOutputEnableN(c3n), .chan3InputEdgeSelect(e3), .chan3BlankingClip(b3));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [VCC_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        // waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdData = prdata;
        errSeen = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic pulse(input bit ch3);
        @(posedge clk_sys);
        if (ch3) ch3Vsync <= 1; else ch2Vsync <= 1;
        @(posedge clk_sys);
        ch2Vsync <= 0;
        ch3Vsync <= 0;
    endtask
    // settle: outputs lag the write edge by up to one cycle, so wait two
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [31:0] ch3Exp(input logic [31:0] d);
        return {d[31], 16'h0000, d[14], 12'h000, d[1:0]};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1;
        #1;
        check({30'h0, d2n, c2n}, 32'h3, "reset oe");
        apb(0, VCC_CHANNEL2_CONTROL_OFS, 0);
        check(rdData, 32'h0, "reset ch2");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            val = (i == 0) ? 32'hffff_ffff : $random(seed);
            apb(1, VCC_CHANNEL2_CONTROL_OFS, val);
            @(posedge clk_sys);
            #1;
            check({31'h0, g2}, {31'h0, val[1]}, "ch2 gate at write");
            check({30'h0, d2n, c2n}, {30'h0, ~val[1], ~val[1]}, "ch2 oe");
            pulse(0);
            settle();
            check({31'h0, a2}, {31'h0, val[0]}, "ch2 active");
            apb(0, VCC_CHANNEL2_CONTROL_OFS, 0);
            check(rdData, val & 32'h3, "ch2 readback");
        end
        $display("test channel 2 done");
        for (int i = 0; i < 6; i++) begin
            apb(1, VCC_CHANNEL3_CONTROL_OFS, 32'h0000_0002);
            pulse(1);
            val = (i == 0) ? 32'hffff_ffff : ($random(seed) | 32'h3);
            apb(1, VCC_CHANNEL3_CONTROL_OFS, val);
            settle();
            check({31'h0, e3}, {31'h0, val[31]}, "ch3 edge");
            check({31'h0, b3}, {31'h0, val[14]}, "ch3 clip");
            check({29'h0, g3, d3n, c3n}, 32'h4, "ch3 gate oe");
            check({31'h0, a3}, 32'h1, "ch3 active");
            apb(1, VCC_CHANNEL3_CONTROL_OFS, val ^ 32'h8000_4000);
            settle();
            check({30'h0, e3, b3}, {30'h0, val[31], val[14]}, "ch3 held until vsync");
            pulse(1);
            settle();
            check({30'h0, e3, b3}, {30'h0, ~val[31], ~val[14]}, "ch3 after vsync");
            apb(0, VCC_CHANNEL3_CONTROL_OFS, 0);
            check(rdData, ch3Exp(val ^ 32'h8000_4000), "ch3 readback");
        end
        $display("test channel 3 done");
        apb(1, 12'h008, 32'hffff_ffff);
        check({31'h0, errSeen}, 32'h1, "unmapped write error");
        apb(0, 12'h008, 0);
        check({31'h0, errSeen}, 32'h1, "unmapped read error");
        check(rdData, 32'h0, "unmapped read data");
        $display("test unmapped done");
        conclude();
    end
endmodule
